// ===== core/fsc_cfg.svh
`ifndef FSC_CFG_SVH
`define FSC_CFG_SVH
`define FSC_CLK_PERIOD_NS   10
`define FSC_CLK_TO_VALID_NS 12
`define FSC_RD_LAT_CYC      ((`FSC_CLK_TO_VALID_NS + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS)
`define FSC_SYNC_STAGES     2
`define FSC_RD_CAPTURE      (`FSC_RD_LAT_CYC + `FSC_SYNC_STAGES)
`define FSC_RST_HOLD_NS     1000
`define FSC_RST_HOLD_CYC    ((`FSC_RST_HOLD_NS + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS)
`define FSC_RESET_US        50
`define FSC_CLK_SYNC_US     20
`define FSC_POWERUP_CYC     ((`FSC_RESET_US + `FSC_CLK_SYNC_US) * 1000 / `FSC_CLK_PERIOD_NS)
`define FSC_DOZE_GUARD_CYC  2
`define FSC_SLEEP_REC_CYC   16
`define FSC_ADDR_W          21
`define FSC_DATA_W          48
`define FSC_LANES           6
`define FSC_BEATS           4
`define FSC_APB_AW          8
`define FSC_OFS_CTRL        8'h00
`define FSC_OFS_ADDR        8'h04
`define FSC_OFS_LANE        8'h08
`define FSC_OFS_STAT        8'h0C
`define FSC_OFS_DATA        8'h10
`define FSC_OFS_DATA_END    8'h2C
`define FSC_CTRL_START      0
`define FSC_CTRL_WRITE      1
`define FSC_CTRL_BEATS      3:2
`define FSC_CTRL_DOZE       4
`define FSC_CTRL_SHUT       5
`define FSC_CTRL_ORDER      6
`define FSC_STAT_BUSY       0
`define FSC_STAT_READY      1
`define FSC_STAT_DOZING     2
`define FSC_STAT_SHUT       3
`define FSC_STAT_DONE       4
`define FSC_STAT_INIT       5
`define FSC_LANE_RESET      6'h3F
`endif

// ===== core/fsc_host.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "fsc_cfg.svh"
module fsc_host #(
	parameter int POWERUP_CYC  = `FSC_POWERUP_CYC,
	parameter int SLEEP_REC_CYC = `FSC_SLEEP_REC_CYC
) (
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`FSC_APB_AW-1:0]  paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	output logic                         clock_gate_n,
	output logic                         advance_or_load_n,
	output logic                         chip_select_a_n,
	output logic                         chip_select_b,
	output logic                         chip_select_c_n,
	output logic                         write_strobe_n,
	output logic      [`FSC_LANES-1:0]   byte_lane_strobe_n,
	output logic      [`FSC_ADDR_W-1:0]  mem_addr,
	output logic      [`FSC_DATA_W-1:0]  dq_out,
	output logic                         dq_oe,
	input  wire logic [`FSC_DATA_W-1:0]  dq_in,
	output logic                         output_gate_n,
	output logic                         doze_request,
	output logic                         shutdown,
	output logic                         mem_reset_n,
	output logic                         burst_order,
	output logic                         mem_clk_run,
	input  wire logic                    ready_in
);
	import fsc_pkg::*;

	localparam logic [15:0] RST_HOLD  = 16'(`FSC_RST_HOLD_CYC);
	localparam logic [15:0] PWR_WAIT  = 16'(POWERUP_CYC);
	localparam logic [15:0] REC_WAIT  = 16'(SLEEP_REC_CYC);
	localparam logic [15:0] GUARD     = 16'(`FSC_DOZE_GUARD_CYC);
	localparam logic [15:0] RD_CAP    = 16'(`FSC_RD_CAPTURE);
	// wait counters are 16 bits wide
	if (POWERUP_CYC < 1 || POWERUP_CYC > 65535 || SLEEP_REC_CYC < 1 || SLEEP_REC_CYC > 65535)
		$error("fsc_host: wait counts out of range");
	fsc_regs_type           s_q;
	fsc_regs_type           s_d;
	logic                   rdy_s;
	logic [`FSC_DATA_W-1:0] dq_s;
	logic                   acc;
	logic                   hit;
	logic [31:0]            rd_mux;
	logic [1:0]             didx;

	// pins from the memory pass two flops
	fsc_sync #(
		.WIDTH (`FSC_DATA_W + 1)
	) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({ready_in, dq_in}),
		.q     ({rdy_s, dq_s})
	);
	assign didx = 2'((paddr - `FSC_OFS_DATA) >> 3);
	always_comb
	begin
		hit    = 1'b1;
		rd_mux = 32'h0;
		if (paddr[1:0] != 2'h0)
			hit = 1'b0;
		else if (paddr == `FSC_OFS_CTRL)
			rd_mux = {25'h0, s_q.cfg_order, s_q.cfg_shut, s_q.cfg_doze, s_q.cfg_nb,
				s_q.cfg_write, 1'b0};
		else if (paddr == `FSC_OFS_ADDR)
			rd_mux = {11'h0, s_q.cfg_addr};
		else if (paddr == `FSC_OFS_LANE)
			rd_mux = {26'h0, s_q.cfg_lanes};
		else if (paddr == `FSC_OFS_STAT)
			rd_mux = {26'h0, s_q.init, s_q.done, s_q.st == S_SHUT,
				s_q.st == S_DOZE, rdy_s, s_q.st != S_IDLE};
		else if (paddr >= `FSC_OFS_DATA && paddr <= `FSC_OFS_DATA_END)
			rd_mux = paddr[2] ? {16'h0, s_q.data[didx][47:32]} : s_q.data[didx][31:0];
		else
			hit = 1'b0;
	end

	assign acc     = psel && penable;
	assign pready  = acc;
	assign pslverr = acc && !hit;

	always_comb
	begin
		s_d = s_q;
		if (psel && !penable)
			s_d.prdata = rd_mux;
		if (acc && pwrite && hit)
		begin
			if (paddr == `FSC_OFS_CTRL)
			begin
				s_d.cfg_write = pwdata[`FSC_CTRL_WRITE];
				s_d.cfg_nb    = pwdata[`FSC_CTRL_BEATS];
				s_d.cfg_doze  = pwdata[`FSC_CTRL_DOZE];
				s_d.cfg_shut  = pwdata[`FSC_CTRL_SHUT];
				s_d.cfg_order = pwdata[`FSC_CTRL_ORDER];
				if (pwdata[`FSC_CTRL_START] && s_q.st == S_IDLE)
					s_d.pend = 1'b1;
			end
			else if (paddr == `FSC_OFS_ADDR)
				s_d.cfg_addr = pwdata[`FSC_ADDR_W-1:0];
			else if (paddr == `FSC_OFS_LANE)
				s_d.cfg_lanes = pwdata[`FSC_LANES-1:0];
			else if (paddr == `FSC_OFS_STAT)
				s_d.done = s_q.done && !pwdata[`FSC_STAT_DONE];
			else if (paddr[2])
				s_d.data[didx][47:32] = pwdata[15:0];
			else
				s_d.data[didx][31:0] = pwdata;
		end
		case (s_q.st)
			S_RST_HOLD:
			begin
				// strap settles while the memory is held in reset
				s_d.order  = s_q.cfg_order;
				s_d.mrst_n = 1'b0;
				s_d.cnt    = s_q.cnt + 16'h1;
				// reset low for the full hold time
				if (s_q.cnt == RST_HOLD - 16'h1)
				begin
					s_d.mrst_n = 1'b1;
					s_d.cnt    = 16'h0;
					s_d.st     = S_RST_WAIT;
				end
			end
			S_RST_WAIT:
			begin
				s_d.cnt = s_q.cnt + 16'h1;
				if (s_q.cnt == PWR_WAIT - 16'h1)
					s_d.st = S_WAIT_RDY;
			end
			S_WAIT_RDY:
			begin
				if (rdy_s)
				begin
					s_d.init = 1'b1;
					s_d.st   = S_IDLE;
				end
			end
			S_IDLE:
			begin
				if (s_q.cfg_shut)
				begin
					// enter shutdown from a deselected idle
					s_d.shdn    = 1'b1;
					s_d.clk_run = 1'b0;
					s_d.init    = 1'b0;
					s_d.pend    = 1'b0;
					s_d.st      = S_SHUT;
				end
				// hold off while the memory reports busy
				else if (s_q.pend && rdy_s)
				begin
					s_d.pend     = 1'b0;
					s_d.op_write = s_q.cfg_write;
					s_d.op_nb    = s_q.cfg_nb;
					// load a new command with all selects active
					s_d.cs_on    = 1'b1;
					s_d.adv_n    = 1'b0;
					s_d.cg_n     = 1'b0;
					s_d.we_n     = !s_q.cfg_write;
					s_d.a        = s_q.cfg_addr;
					// lane strobes only matter for writes
					s_d.lane_n   = s_q.cfg_write ? ~s_q.cfg_lanes : {`FSC_LANES{1'b1}};
					// output gate low only for reads
					s_d.oe_n     = s_q.cfg_write;
					s_d.beat     = 3'h0;
					s_d.cnt      = 16'h0;
					s_d.st       = s_q.cfg_write ? S_WR : S_RD;
				end
				else if (s_q.cfg_doze && !s_q.pend)
				begin
					s_d.cnt = 16'h0;
					s_d.st  = S_DOZE_IN;
				end
			end
			S_WR:
			begin
				// data for each beat stands for the following edge
				s_d.dq_o  = s_q.data[s_q.beat[1:0]];
				s_d.dq_oe = 1'b1;
				s_d.beat  = s_q.beat + 3'h1;
				if (s_q.beat < {1'b0, s_q.op_nb})
					s_d.adv_n = 1'b1;
				else
				begin
					// deselect by a load with selects idle
					s_d.cs_on = 1'b0;
					s_d.adv_n = 1'b0;
					s_d.we_n  = 1'b1;
					s_d.st    = S_WR_END;
				end
			end
			S_WR_END:
			begin
				s_d.dq_oe  = 1'b0;
				s_d.lane_n = {`FSC_LANES{1'b1}};
				s_d.done   = 1'b1;
				s_d.st     = S_IDLE;
			end
			S_RD:
			begin
				s_d.cnt = s_q.cnt + 16'h1;
				// stall the clock gate until data clears the synchroniser
				if (s_q.cnt == 16'h0)
					s_d.cg_n = 1'b1;
				if (s_q.cnt == RD_CAP)
				begin
					s_d.data[s_q.beat[1:0]] = dq_s;
					s_d.cnt  = 16'h0;
					s_d.cg_n = 1'b0;
					if (s_q.beat < {1'b0, s_q.op_nb})
					begin
						// continuation beat, memory steps its own counter
						s_d.adv_n = 1'b1;
						s_d.beat  = s_q.beat + 3'h1;
					end
					else
					begin
						s_d.cs_on = 1'b0;
						s_d.adv_n = 1'b0;
						s_d.oe_n  = 1'b1;
						s_d.done  = 1'b1;
						s_d.st    = S_IDLE;
					end
				end
			end
			S_DOZE_IN:
			begin
				s_d.cnt = s_q.cnt + 16'h1;
				if (!s_q.cfg_doze)
					s_d.st = S_IDLE;
				else if (s_q.cnt == GUARD)
				begin
					s_d.doze    = 1'b1;
					s_d.clk_run = 1'b0;
					s_d.st      = S_DOZE;
				end
			end
			S_DOZE:
			begin
				if (!s_q.cfg_doze)
				begin
					s_d.doze    = 1'b0;
					// clock back on when doze ends
					s_d.clk_run = 1'b1;
					s_d.cnt     = 16'h0;
					s_d.st      = S_DOZE_OUT;
				end
			end
			S_DOZE_OUT:
			begin
				s_d.cnt = s_q.cnt + 16'h1;
				if (s_q.cnt == REC_WAIT - 16'h1)
					s_d.st = S_IDLE;
			end
			S_SHUT:
			begin
				if (!s_q.cfg_shut)
				begin
					// leaving shutdown always resets the memory
					s_d.shdn    = 1'b0;
					s_d.clk_run = 1'b1;
					s_d.mrst_n  = 1'b0;
					s_d.cnt     = 16'h0;
					s_d.st      = S_RST_HOLD;
				end
			end
			default:
				s_d.st = S_RST_HOLD;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_q           <= '0;
			s_q.st        <= S_RST_HOLD;
			s_q.cfg_lanes <= `FSC_LANE_RESET;
			s_q.we_n      <= 1'b1;
			s_q.lane_n    <= {`FSC_LANES{1'b1}};
			s_q.oe_n      <= 1'b1;
			s_q.clk_run   <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign prdata             = s_q.prdata;
	assign clock_gate_n       = s_q.cg_n;
	assign advance_or_load_n  = s_q.adv_n;
	assign chip_select_a_n    = !s_q.cs_on;
	assign chip_select_b      = s_q.cs_on;
	assign chip_select_c_n    = !s_q.cs_on;
	assign write_strobe_n     = s_q.we_n;
	assign byte_lane_strobe_n = s_q.lane_n;
	assign mem_addr           = s_q.a;
	assign dq_out             = s_q.dq_o;
	assign dq_oe              = s_q.dq_oe;
	assign output_gate_n      = s_q.oe_n;
	assign doze_request       = s_q.doze;
	assign shutdown           = s_q.shdn;
	assign mem_reset_n        = s_q.mrst_n;
	assign burst_order        = s_q.order;
	assign mem_clk_run        = s_q.clk_run;

	localparam int CHK_HOLD = 100;
	logic [7:0] low_cnt_q;

	always_ff @(posedge clk)
	begin
		if (reset || s_q.mrst_n)
			low_cnt_q <= 8'h0;
		else if (low_cnt_q != 8'hFF)
			low_cnt_q <= low_cnt_q + 8'h1;
	end
	sequence read_load;
		s_q.cs_on && !s_q.adv_n && s_q.we_n && !s_q.cg_n;
	endsequence
	sequence write_load;
		s_q.cs_on && !s_q.adv_n && !s_q.we_n && !s_q.cg_n;
	endsequence
	chk_read_stall_gate: assert property (@(posedge clk) disable iff (reset)
		read_load |=> s_q.cg_n [*4] ##1 !s_q.cg_n)
		else $error("read stall length wrong");
	chk_read_out_gate: assert property (@(posedge clk) disable iff (reset)
		read_load |-> !s_q.oe_n ##1 !s_q.oe_n [*4])
		else $error("output gate not low during read");
	chk_write_data_beat: assert property (@(posedge clk) disable iff (reset)
		write_load |=> s_q.dq_oe && s_q.dq_o == s_q.data[0])
		else $error("write data not driven after load");
	chk_no_contention: assert property (@(posedge clk) disable iff (reset)
		s_q.dq_oe |-> s_q.oe_n)
		else $error("data driven with output gate low");
	chk_load_after_idle: assert property (@(posedge clk) disable iff (reset)
		$rose(s_q.cs_on) |-> !s_q.adv_n && !s_q.cg_n)
		else $error("new command without load");
	chk_access_ready: assert property (@(posedge clk) disable iff (reset)
		$rose(s_q.cs_on) |-> $past(rdy_s) && s_q.init)
		else $error("access issued while not ready");
	chk_doze_guard: assert property (@(posedge clk) disable iff (reset)
		$rose(s_q.doze) |-> !$past(s_q.cs_on, 1) && !$past(s_q.cs_on, 2)
			&& !$past(s_q.cs_on, 3))
		else $error("doze raised too soon");
	chk_doze_desel: assert property (@(posedge clk) disable iff (reset)
		$fell(s_q.doze) |-> !s_q.cs_on [*8])
		else $error("selected during doze recovery");
	chk_reset_hold: assert property (@(posedge clk) disable iff (reset)
		$rose(s_q.mrst_n) |-> $past(low_cnt_q) >= CHK_HOLD - 1)
		else $error("memory reset pulse too short");
	chk_shut_reset: assert property (@(posedge clk) disable iff (reset)
		$fell(s_q.shdn) |-> !s_q.mrst_n && s_q.clk_run)
		else $error("no memory reset after shutdown");
	chk_strap_static: assert property (@(posedge clk) disable iff (reset)
		s_q.mrst_n && $past(s_q.mrst_n) |-> $stable(s_q.order))
		else $error("burst order changed outside reset");
	chk_clock_run: assert property (@(posedge clk) disable iff (reset)
		!s_q.clk_run |-> s_q.doze || s_q.shdn)
		else $error("memory clock stopped outside doze or shutdown");
endmodule // fsc_host

// ===== core/fsc_pkg.sv
`include "fsc_cfg.svh"
package fsc_pkg;
	typedef enum {
		S_RST_HOLD, S_RST_WAIT, S_WAIT_RDY, S_IDLE, S_WR, S_WR_END,
		S_RD, S_DOZE_IN, S_DOZE, S_DOZE_OUT, S_SHUT
	} fsc_state_type;

	typedef struct packed {
		fsc_state_type                           st;
		logic [15:0]                             cnt;
		logic [2:0]                              beat;
		logic [1:0]                              cfg_nb;
		logic                                    cfg_write;
		logic                                    cfg_doze;
		logic                                    cfg_shut;
		logic                                    cfg_order;
		logic [`FSC_ADDR_W-1:0]                  cfg_addr;
		logic [`FSC_LANES-1:0]                   cfg_lanes;
		logic                                    pend;
		logic                                    done;
		logic                                    init;
		logic [1:0]                              op_nb;
		logic                                    op_write;
		logic [`FSC_BEATS-1:0][`FSC_DATA_W-1:0]  data;
		logic [31:0]                             prdata;
		logic                                    cg_n;
		logic                                    adv_n;
		logic                                    cs_on;
		logic                                    we_n;
		logic [`FSC_LANES-1:0]                   lane_n;
		logic [`FSC_ADDR_W-1:0]                  a;
		logic [`FSC_DATA_W-1:0]                  dq_o;
		logic                                    dq_oe;
		logic                                    oe_n;
		logic                                    doze;
		logic                                    shdn;
		logic                                    mrst_n;
		logic                                    clk_run;
		logic                                    order;
	} fsc_regs_type;
endpackage

// ===== core/fsc_sync.sv
`timescale 1ns/1ps
module fsc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // fsc_sync

// ===== test/fsc_mem_model.sv
`timescale 1ns/1ps
module fsc_mem_model #(
	parameter int RDY_CYC = 8
) (
	input  wire logic        clk,
	input  wire logic        clock_gate_n,
	input  wire logic        advance_or_load_n,
	input  wire logic        chip_select_a_n,
	input  wire logic        chip_select_b,
	input  wire logic        chip_select_c_n,
	input  wire logic        write_strobe_n,
	input  wire logic [5:0]  byte_lane_strobe_n,
	input  wire logic [20:0] mem_addr,
	input  wire logic [47:0] dq_out,
	input  wire logic        dq_oe,
	input  wire logic        output_gate_n,
	input  wire logic        doze_request,
	input  wire logic        shutdown,
	input  wire logic        mem_reset_n,
	input  wire logic        burst_order,
	input  wire logic        hk_busy,
	output wire logic [47:0] dq,
	output wire logic        ready,
	output wire logic        fault
);
	logic [47:0] store [logic [20:0]];
	logic        act, wr, wpend, mode;
	logic        on = 1'b0;
	logic        fault_q = 1'b0;
	logic [20:0] base, wadr;
	logic [1:0]  beat;
	logic [47:0] t;
	logic [47:0] drv = 48'h0;
	int          rcnt, lcnt = 0;
	int          ecnt = 0, vcnt = 0;
	wire         sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;

	function automatic logic [47:0] peek(input logic [20:0] a);
		return store.exists(a) ? store[a] : 48'h0;
	endfunction

	// order of the low address bits
	function automatic logic [20:0] nxt(input logic [1:0] b);
		return {base[20:2], mode ? base[1:0] ^ b : base[1:0] + b};
	endfunction

	assign dq = (on && !output_gate_n && ecnt == vcnt) ? drv : ~drv;
	// ready after recovery, low while busy
	assign ready = rcnt >= RDY_CYC && !hk_busy && !shutdown;
	assign fault = fault_q;

	always @(posedge clk or posedge shutdown)
	begin
		if (shutdown)
		begin
			store.delete();
			on <= 1'b0;
			rcnt <= 0;
		end
		else if (!mem_reset_n)
		begin
			mode <= burst_order;
			act <= 1'b0;
			on <= 1'b0;
			wpend <= 1'b0;
			rcnt <= 0;
			lcnt <= lcnt + 1;
		end
		else
		begin
			if (lcnt > 0 && lcnt < 100)
				fault_q <= 1'b1;
			lcnt <= 0;
			if (rcnt < RDY_CYC)
				rcnt <= rcnt + 1;
			if ((on && !output_gate_n && dq_oe) || (doze_request && sel))
				fault_q <= 1'b1;
			if (!clock_gate_n && !doze_request)
			begin
				if (wpend)
				begin
					t = peek(wadr);
					for (int l = 0; l < 6; l++)
						if (!byte_lane_strobe_n[l])
							t[8*l +: 8] = dq_out[8*l +: 8];
					store[wadr] = t;
				end
				if (!advance_or_load_n)
				begin
					act <= sel;
					wr <= !write_strobe_n;
					base <= mem_addr;
					beat <= 2'd0;
					wpend <= sel && !write_strobe_n;
					wadr <= mem_addr;
					on <= sel && write_strobe_n;
					t = peek(mem_addr);
				end
				else
				begin
					beat <= beat + 2'd1;
					wpend <= act && wr;
					wadr <= nxt(beat + 2'd1);
					on <= act && !wr;
					t = peek(nxt(beat + 2'd1));
				end
				ecnt <= ecnt + 1;
				vcnt <= #12 ecnt + 1;
				drv <= #12 t;
			end
		end
	end
endmodule // fsc_mem_model

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
	import fsc_pkg::*;
	logic        clk, reset, psel, penable, pwrite, hk_busy, er, ord;
	logic [7:0]  paddr;
	logic [31:0] pwdata, rd;
	logic [47:0] v;
	int          miscompares, checks_done;
	wire         pready, pslverr, clock_gate_n, advance_or_load_n, chip_select_a_n;
	wire         chip_select_b, chip_select_c_n, write_strobe_n, dq_oe, output_gate_n;
	wire         doze_request, shutdown, mem_reset_n, burst_order, mem_clk_run, ready, fault;
	wire [5:0]   byte_lane_strobe_n;
	wire [20:0]  mem_addr;
	wire [31:0]  prdata;
	wire [47:0]  dq_out, dq;

	fsc_host #(.POWERUP_CYC(20), .SLEEP_REC_CYC(2)) uut (.clk, .reset, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clock_gate_n,
		.advance_or_load_n, .chip_select_a_n, .chip_select_b, .chip_select_c_n,
		.write_strobe_n, .byte_lane_strobe_n, .mem_addr, .dq_out, .dq_oe, .dq_in(dq),
		.output_gate_n, .doze_request, .shutdown, .mem_reset_n, .burst_order,
		.mem_clk_run, .ready_in(ready));

	fsc_mem_model mem (.clk, .clock_gate_n, .advance_or_load_n, .chip_select_a_n,
		.chip_select_b, .chip_select_c_n, .write_strobe_n, .byte_lane_strobe_n, .mem_addr,
		.dq_out, .dq_oe, .output_gate_n, .doze_request, .shutdown, .mem_reset_n,
		.burst_order, .hk_busy, .dq, .ready, .fault);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [47:0] pat(input int i);
		return 48'h5A5A_0000_0000 | (48'h0101_0101 * (i + 1));
	endfunction

	task test_done;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input logic [47:0] g, input logic [47:0] e);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task chk_bit(input logic g, input logic e);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch at %0t: got %b expected %b", $time, g, e);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// poll a status bit, clear done once seen
	task wait_st(input int b, input logic val);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, 8'h0C, 32'h0);
			n++;
		end
		while (rd[b] !== val && n < 500);
		chk_bit(rd[b], val);
		if (b == 4)
			apb(1'b1, 8'h0C, 32'h10);
	endtask

	task dat(input int i, input logic [47:0] d);
		apb(1'b1, 8'h10 + 8'(8 * i), d[31:0]);
		apb(1'b1, 8'h14 + 8'(8 * i), {16'h0, d[47:32]});
	endtask

	task get(input int i);
		apb(1'b0, 8'h10 + 8'(8 * i), 32'h0);
		v[31:0] = rd;
		apb(1'b0, 8'h14 + 8'(8 * i), 32'h0);
		v[47:32] = rd[15:0];
	endtask

	task mop(input logic w, input logic [20:0] a, input logic [1:0] nb, input logic wt);
		apb(1'b1, 8'h04, {11'h0, a});
		apb(1'b1, 8'h00, {25'h0, ord, 2'b00, nb, w, 1'b1});
		if (wt)
			wait_st(4, 1'b1);
	endtask

	initial
	begin
		reset = 1'b1;
		{psel, penable, pwrite, hk_busy, ord} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		miscompares = 0;
		checks_done = 0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		apb(1'b0, 8'h08, 32'h0);
		chk({16'h0, rd}, 48'h3F);
		wait_st(5, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
			dat(i, pat(i));
		mop(1'b1, 21'h000101, 2'd3, 1'b1);
		for (int i = 0; i < 4; i++)
			chk(mem.peek({19'h40, 2'(i + 1)}), pat(i));
		for (int i = 0; i < 4; i++)
			dat(i, 48'h0);
		mop(1'b0, 21'h000101, 2'd3, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			get(i);
			chk(v, pat(i));
		end
		$display("test linear burst done");
		apb(1'b1, 8'h08, 32'h15);
		dat(0, 48'hFFFF_FFFF_FFFF);
		mop(1'b1, 21'h000102, 2'd0, 1'b1);
		chk(mem.peek(21'h000102), pat(1) | 48'h00FF_00FF_00FF);
		apb(1'b1, 8'h08, 32'h3F);
		apb(1'b1, 8'h30, 32'h1);
		chk_bit(er, 1'b1);
		apb(1'b0, 8'h02, 32'h0);
		chk({15'h0, er, rd}, 48'h1_0000_0000);
		$display("test lanes and refusals done");
		apb(1'b1, 8'h00, 32'h10);
		wait_st(2, 1'b1);
		chk_bit(doze_request, 1'b1);
		chk_bit(mem_clk_run, 1'b0);
		apb(1'b1, 8'h00, 32'h0);
		wait_st(0, 1'b0);
		chk_bit(mem_clk_run, 1'b1);
		mop(1'b0, 21'h000100, 2'd0, 1'b1);
		get(0);
		chk(v, pat(3));
		$display("test doze done");
		hk_busy <= !hk_busy; // housekeeping busy on
		wait_st(1, 1'b0);
		dat(0, pat(5));
		mop(1'b1, 21'h000100, 2'd0, 1'b0);
		repeat (30) @(posedge clk);
		chk(mem.peek(21'h000100), pat(3));
		hk_busy <= !hk_busy; // housekeeping busy off
		wait_st(4, 1'b1);
		chk(mem.peek(21'h000100), pat(5));
		$display("test housekeeping done");
		ord = 1'b1;
		apb(1'b1, 8'h00, 32'h60);
		wait_st(3, 1'b1);
		chk_bit(shutdown, 1'b1);
		chk_bit(mem_clk_run, 1'b0);
		chk(mem.peek(21'h000101), 48'h0);
		apb(1'b1, 8'h00, 32'h40);
		wait_st(0, 1'b0);
		chk_bit(burst_order, 1'b1);
		for (int i = 0; i < 4; i++)
			dat(i, pat(i + 4));
		mop(1'b1, 21'h000101, 2'd3, 1'b1);
		for (int i = 0; i < 4; i++)
			chk(mem.peek({19'h40, 2'b01 ^ 2'(i)}), pat(i + 4));
		chk_bit(fault, 1'b0);
		$display("test shutdown and interleave done");
		test_done;
	end

	initial
	begin
		#800000;
		miscompares++;
		$display("mismatch at %0t: timeout", $time);
		test_done;
	end
endmodule // tb
